/* File: rtl/cacc_regs.vh */
`ifndef CACC_REGS_VH
`define CACC_REGS_VH

// Register addresses on the special function register port.
`define CACC_ADDR_CONTROL 8'hc0
`define CACC_ADDR_COUNT_MODE 8'hc1
`define CACC_ADDR_TIMER_LOW 8'hc2
`define CACC_ADDR_TIMER_HIGH 8'hc3
`define CACC_ADDR_FUNC_BASE 8'hd0
`define CACC_ADDR_VLOW_BASE 8'he0
`define CACC_ADDR_VHIGH_BASE 8'hf0

// Control flags register fields.
`define CACC_CTL_OVERFLOW 7
`define CACC_CTL_RUN 6
`define CACC_CTL_EVENT_MSB 4
`define CACC_CTL_RESET 8'h00

// Count mode register fields.
`define CACC_MOD_IDLE_STOP 7
`define CACC_MOD_WATCHDOG 6
`define CACC_MOD_SRC_HI 2
`define CACC_MOD_SRC_LO 1
`define CACC_MOD_OVF_IRQ 0
`define CACC_MOD_RESET 8'h00

// Module function select fields.
`define CACC_FN_IRQ 0
`define CACC_FN_PWM 1
`define CACC_FN_TOGGLE 2
`define CACC_FN_MATCH 3
`define CACC_FN_CAP_FALL 4
`define CACC_FN_CAP_RISE 5
`define CACC_FN_COMPARE 6
`define CACC_FN_RESET 7'h00

// Count source codes and prescaler divisors.
`define CACC_SRC_OSC_SLOW 2'h0
`define CACC_SRC_OSC_FAST 2'h1
`define CACC_SRC_TIMER0 2'h2
`define CACC_SRC_EXTERNAL 2'h3
`define CACC_DIV_SLOW_6CLK 4'h6
`define CACC_DIV_SLOW_12CLK 4'hc
`define CACC_DIV_FAST_6CLK 4'h2
`define CACC_DIV_FAST_12CLK 4'h4
`define CACC_TIMER_STEP 16'h0001
`define CACC_TIMER_MAX 16'hffff
`define CACC_LOW_MAX 8'hff

// Reset values of data registers and pins.
`define CACC_TIMER_RESET 16'h0000
`define CACC_VALUE_RESET 8'h00
`define CACC_PIN_RESET 1'b1
`define CACC_PRESCALE_RESET 4'h0
`define CACC_READ_RESET 8'h00
`define CACC_OE_RESET 5'h00
`define CACC_FLAG_RESET 1'b0

`endif

/* File: rtl/cacc_module.v */
`timescale 1ns/1ns
`default_nettype none
`include "cacc_regs.vh"

module cacc_module
(
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Configuration and time base.
    input wire [6:0] mode,
    input wire [15:0] timerNow,
    input wire [15:0] timerNext,
    input wire tick,
    input wire lowWrap,
    // Software access to the value bytes.
    input wire wrLow,
    input wire wrHigh,
    input wire [7:0] wrData,
    // Synchronised pin level.
    input wire pinLevel,
    // Results.
    output reg [7:0] valueLow_q,
    output reg [7:0] valueHigh_q,
    output wire eventHit,
    output wire matchHit,
    output reg pinOut_q
);

    reg pinPrev_q;
    wire rise;
    wire fall;
    wire capture;
    wire pwmMode;

    assign rise = pinLevel & ~pinPrev_q;
    assign fall = ~pinLevel & pinPrev_q;
    assign capture = (rise & mode[`CACC_FN_CAP_RISE]) | (fall & mode[`CACC_FN_CAP_FALL]);
    assign matchHit = mode[`CACC_FN_COMPARE] & tick & (timerNext == {valueHigh_q, valueLow_q});
    assign eventHit = capture | (matchHit & mode[`CACC_FN_MATCH]);
    assign pwmMode = mode[`CACC_FN_PWM] & mode[`CACC_FN_COMPARE];

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pinPrev_q <= `CACC_PIN_RESET;
            valueLow_q <= `CACC_VALUE_RESET;
            valueHigh_q <= `CACC_VALUE_RESET;
            pinOut_q <= `CACC_PIN_RESET;
        end
        else
        begin
            pinPrev_q <= pinLevel;
            if (capture)
            begin
                valueLow_q <= timerNow[7:0];
                valueHigh_q <= timerNow[15:8];
            end
            else
            begin
                if (wrHigh)
                    valueHigh_q <= wrData;
                if (wrLow)
                    valueLow_q <= wrData;
                else if (pwmMode && lowWrap)
                    valueLow_q <= valueHigh_q;
            end
            if (pwmMode)
                pinOut_q <= (timerNow[7:0] >= valueLow_q);
            else if (matchHit && mode[`CACC_FN_TOGGLE])
                pinOut_q <= ~pinOut_q;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/cacc_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "cacc_regs.vh"

module cacc_top
(
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Special function register port.
    input wire [7:0] sfrAddr,
    input wire sfrWrEn,
    input wire [7:0] sfrWrData,
    input wire sfrRdEn,
    output reg [7:0] sfrRdData_q,
    // Processor state.
    input wire sixClockMode,
    input wire idleMode,
    input wire timer0Overflow,
    // Pins.
    input wire externalCountInput,
    input wire [4:0] modulePinIn,
    output wire [4:0] modulePinOut,
    output reg [4:0] modulePinOe_q,
    // Requests to the processor.
    output reg irqRequest_q,
    output reg watchdogReset_q
);

    localparam NUM_MODULES = 5;

    // Returns a one-hot hit vector for five consecutive addresses from base.
    function [4:0] decodeModule;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] diff;
        begin
            diff = addr - base;
            decodeModule = 5'h00;
            if (diff < 8'h05)
                decodeModule[diff[2:0]] = 1'b1;
        end
    endfunction

    reg [7:0] control_q;
    reg [7:0] countMode_q;
    reg [15:0] timer_q;
    reg [3:0] prescale_q;
    reg [6:0] funcSel_q [0:4];
    reg [4:0] pinMeta_q;
    reg [4:0] pinSync_q;
    reg extMeta_q;
    reg extSync_q;
    reg extPrev_q;

    wire [4:0] funcHit;
    wire [4:0] lowHit;
    wire [4:0] highHit;
    wire [4:0] eventHit;
    wire [4:0] matchHit;
    wire [39:0] valueLowBus;
    wire [39:0] valueHighBus;
    wire [4:0] irqEnables;
    wire [1:0] countSource;
    wire [15:0] timerNext;
    wire [3:0] divisor;
    wire prescaleTick;
    wire extFall;
    wire countEnable;
    wire tick;
    wire lowWrap;
    wire overflow;
    wire wrControl;
    wire wrCountMode;
    wire wrTimerLow;
    wire wrTimerHigh;
    wire timerWrite;
    wire [4:0] funcWr;
    wire [4:0] lowWr;
    wire [4:0] highWr;
    reg sourceTick;
    reg [7:0] readMux;
    reg [7:0] control_d;
    reg [4:0] oeMux;
    integer i;

    assign funcHit = decodeModule(sfrAddr, `CACC_ADDR_FUNC_BASE);
    assign lowHit = decodeModule(sfrAddr, `CACC_ADDR_VLOW_BASE);
    assign highHit = decodeModule(sfrAddr, `CACC_ADDR_VHIGH_BASE);
    assign wrControl = sfrWrEn & (sfrAddr == `CACC_ADDR_CONTROL);
    assign wrCountMode = sfrWrEn & (sfrAddr == `CACC_ADDR_COUNT_MODE);
    assign wrTimerLow = sfrWrEn & (sfrAddr == `CACC_ADDR_TIMER_LOW);
    assign wrTimerHigh = sfrWrEn & (sfrAddr == `CACC_ADDR_TIMER_HIGH);
    assign timerWrite = wrTimerLow | wrTimerHigh;
    assign funcWr = {NUM_MODULES{sfrWrEn}} & funcHit;
    assign lowWr = {NUM_MODULES{sfrWrEn}} & lowHit;
    assign highWr = {NUM_MODULES{sfrWrEn}} & highHit;

    // Pins cross two flip-flops before any logic sees them.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pinMeta_q <= {NUM_MODULES{`CACC_PIN_RESET}};
            pinSync_q <= {NUM_MODULES{`CACC_PIN_RESET}};
        end
        else
        begin
            pinMeta_q <= modulePinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // The count input resets to its idle pull-up level, so no false edge follows reset.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            extMeta_q <= `CACC_PIN_RESET;
            extSync_q <= `CACC_PIN_RESET;
            extPrev_q <= `CACC_PIN_RESET;
        end
        else
        begin
            extMeta_q <= externalCountInput;
            extSync_q <= extMeta_q;
            extPrev_q <= extSync_q;
        end
    end

    // The external count input advances the timer on its falling edge.
    assign extFall = extPrev_q & ~extSync_q;

    assign countSource = {countMode_q[`CACC_MOD_SRC_HI], countMode_q[`CACC_MOD_SRC_LO]};
    assign divisor = (countSource == `CACC_SRC_OSC_SLOW) ?
        (sixClockMode ? `CACC_DIV_SLOW_6CLK : `CACC_DIV_SLOW_12CLK) :
        (sixClockMode ? `CACC_DIV_FAST_6CLK : `CACC_DIV_FAST_12CLK);
    assign prescaleTick = (prescale_q == divisor - 4'h1);

    always @*
    begin
        case (countSource)
            `CACC_SRC_OSC_SLOW: sourceTick = prescaleTick;
            `CACC_SRC_OSC_FAST: sourceTick = prescaleTick;
            `CACC_SRC_TIMER0: sourceTick = timer0Overflow;
            `CACC_SRC_EXTERNAL: sourceTick = extFall;
            default: sourceTick = 1'b0;
        endcase
    end

    assign countEnable = control_q[`CACC_CTL_RUN] &
        ~(countMode_q[`CACC_MOD_IDLE_STOP] & idleMode);
    // A timer byte write overrides the count event of the same cycle, so a reload
    // never also raises an overflow, a wrap or a match on the stale count.
    assign tick = countEnable & sourceTick & ~timerWrite;
    assign timerNext = timer_q + `CACC_TIMER_STEP;
    assign overflow = tick & (timer_q == `CACC_TIMER_MAX);
    assign lowWrap = tick & (timer_q[7:0] == `CACC_LOW_MAX);

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prescale_q <= `CACC_PRESCALE_RESET;
            timer_q <= `CACC_TIMER_RESET;
        end
        else
        begin
            if (!countEnable || prescaleTick || prescale_q >= divisor)
                prescale_q <= 4'h0;
            else
                prescale_q <= prescale_q + 4'h1;
            if (timerWrite)
            begin
                if (wrTimerLow)
                    timer_q[7:0] <= sfrWrData;
                if (wrTimerHigh)
                    timer_q[15:8] <= sfrWrData;
            end
            else if (tick)
                timer_q <= timerNext;
        end
    end

    // Control flags: hardware set wins over a software write in the same cycle.
    always @*
    begin
        control_d = wrControl ? sfrWrData : control_q;
        control_d[5] = 1'b0;
        if (overflow)
            control_d[`CACC_CTL_OVERFLOW] = 1'b1;
        control_d[`CACC_CTL_EVENT_MSB:0] = control_d[`CACC_CTL_EVENT_MSB:0] | eventHit;
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            control_q <= `CACC_CTL_RESET;
            countMode_q <= `CACC_MOD_RESET;
        end
        else
        begin
            control_q <= control_d;
            if (wrCountMode)
                countMode_q <= sfrWrData;
        end
    end

    // Each module has its own function select and value bytes.
    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g = g + 1)
        begin : gen_mod
            always @(posedge clk or posedge reset)
            begin
                if (reset)
                    funcSel_q[g] <= `CACC_FN_RESET;
                else if (funcWr[g])
                    funcSel_q[g] <= sfrWrData[6:0];
            end

            assign irqEnables[g] = funcSel_q[g][`CACC_FN_IRQ];

            cacc_module u_module
            (
                .clk(clk),
                .reset(reset),
                .mode(funcSel_q[g]),
                .timerNow(timer_q),
                .timerNext(timerNext),
                .tick(tick),
                .lowWrap(lowWrap),
                .wrLow(lowWr[g]),
                .wrHigh(highWr[g]),
                .wrData(sfrWrData),
                .pinLevel(pinSync_q[g]),
                .valueLow_q(valueLowBus[8*g +: 8]),
                .valueHigh_q(valueHighBus[8*g +: 8]),
                .eventHit(eventHit[g]),
                .matchHit(matchHit[g]),
                .pinOut_q(modulePinOut[g])
            );
        end
    endgenerate

    // A module drives its pin only in toggle or PWM operation.
    always @*
    begin
        oeMux = 5'h00;
        for (i = 0; i < NUM_MODULES; i = i + 1)
            oeMux[i] = funcSel_q[i][`CACC_FN_COMPARE] &
                (funcSel_q[i][`CACC_FN_TOGGLE] | funcSel_q[i][`CACC_FN_PWM]);
    end

    // Read data; unmapped addresses read as zero.
    always @*
    begin
        readMux = 8'h00;
        if (sfrAddr == `CACC_ADDR_CONTROL)
            readMux = control_q;
        else if (sfrAddr == `CACC_ADDR_COUNT_MODE)
            readMux = countMode_q;
        else if (sfrAddr == `CACC_ADDR_TIMER_LOW)
            readMux = timer_q[7:0];
        else if (sfrAddr == `CACC_ADDR_TIMER_HIGH)
            readMux = timer_q[15:8];
        for (i = 0; i < NUM_MODULES; i = i + 1)
        begin
            if (funcHit[i])
                readMux = {1'b0, funcSel_q[i]};
            if (lowHit[i])
                readMux = valueLowBus[8*i +: 8];
            if (highHit[i])
                readMux = valueHighBus[8*i +: 8];
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
            sfrRdData_q <= `CACC_READ_RESET;
        else if (sfrRdEn)
            sfrRdData_q <= readMux;
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
            modulePinOe_q <= `CACC_OE_RESET;
        else
            modulePinOe_q <= oeMux;
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
            irqRequest_q <= `CACC_FLAG_RESET;
        else
            irqRequest_q <= (control_q[`CACC_CTL_OVERFLOW] & countMode_q[`CACC_MOD_OVF_IRQ]) |
                (|(control_q[`CACC_CTL_EVENT_MSB:0] & irqEnables));
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
            watchdogReset_q <= `CACC_FLAG_RESET;
        else
            watchdogReset_q <= countMode_q[`CACC_MOD_WATCHDOG] & matchHit[4];
    end

endmodule

`default_nettype wire

/* File: verification/cacc_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cacc_chk
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register port and outputs.
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrRdData_q,
    input wire logic [4:0] modulePinOe_q,
    input wire logic watchdogReset_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence wrThenRd(a);
        sfrWrEn && sfrAddr == a ##1 sfrRdEn && !sfrWrEn && sfrAddr == a;
    endsequence
    unmapped_read_a:
    assert property (sfrRdEn && sfrAddr == 8'h80 |=> sfrRdData_q == 8'h00)
        else $error("Unmapped read not zero.");
    ctl_bit5_a:
    assert property (sfrRdEn && sfrAddr == 8'hc0 |=> !sfrRdData_q[5])
        else $error("Control bit 5 read as one.");
    func_bit7_a:
    assert property (sfrRdEn && sfrAddr >= 8'hd0 && sfrAddr <= 8'hd4 |=> !sfrRdData_q[7])
        else $error("Function bit 7 read as one.");
    read_hold_a:
    assert property (!sfrRdEn |=> $stable(sfrRdData_q))
        else $error("Read data moved without a read.");
    wdog_pulse_a:
    assert property (watchdogReset_q |=> !watchdogReset_q)
        else $error("Watchdog reset longer than one cycle.");
    oe_off_a:
    assert property (sfrWrEn && sfrAddr == 8'hd3 && !sfrWrData[6] |-> ##[1:2] !modulePinOe_q[3])
        else $error("Pin still driven with comparator off.");
    run_readback_a:
    assert property (wrThenRd(8'hc0) |=> sfrRdData_q[6] == $past(sfrWrData[6], 2))
        else $error("Run bit not as written.");
    mode_readback_a:
    assert property (wrThenRd(8'hc1) |=> sfrRdData_q == $past(sfrWrData, 2))
        else $error("Count mode not as written.");
endmodule
bind cacc_top cacc_chk chk_u (.clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData_q(sfrRdData_q),
    .modulePinOe_q(modulePinOe_q), .watchdogReset_q(watchdogReset_q));
`default_nettype wire

/* File: verification/cacc_pins.sv */
`timescale 1ns/1ns
`default_nettype none
module cacc_pins
(
    // Design side.
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe,
    output wire logic [4:0] pinIn,
    output wire logic extCount,
    // Stimulus side.
    input wire logic [4:0] pinDrive,
    input wire logic extCountDrive
);
    // pin level
    // A pin that the module drives shows the module's level, else the outside driver's.
    assign pinIn = (pinOe & pinOut) | (~pinOe & pinDrive);
    assign extCount = extCountDrive;
endmodule
`default_nettype wire

/* File: verification/test_cacc_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cacc_regs.vh"
module test_cacc_top;
    localparam [7:0] CTL = `CACC_ADDR_CONTROL;
    localparam [7:0] MD = `CACC_ADDR_COUNT_MODE;
    logic clk = 1'b0, reset = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, sixClockMode = 1'b0;
    // The count input idles high, the level its pull-up would hold.
    logic idleMode = 1'b0, timer0Overflow = 1'b0, extCountDrive = 1'b1;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, v, w;
    logic [4:0] pinDrive = 5'h1f;
    wire [7:0] rdData;
    wire [4:0] pinIn, pinOut, pinOe;
    wire extCount, irq, wdog;
    int mismatches = 0, checks = 0, cycles = 0, wdCount = 0, i, e;
    cacc_top dut_u (.clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData_q(rdData),
        .sixClockMode(sixClockMode), .idleMode(idleMode), .timer0Overflow(timer0Overflow),
        .externalCountInput(extCount), .modulePinIn(pinIn), .modulePinOut(pinOut),
        .modulePinOe_q(pinOe), .irqRequest_q(irq), .watchdogReset_q(wdog));
    cacc_pins pins_u (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .extCount(extCount),
        .pinDrive(pinDrive), .extCountDrive(extCountDrive));
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (wdog === 1'b1) wdCount++;
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    // Strobes stay up between back-to-back accesses; wt and pulses drop them.
    task automatic wr(input [7:0] a, input [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrRdEn = 1'b0;
        sfrWrEn = 1'b1;
        @(negedge clk);
    endtask
    task automatic rd(input [7:0] a, output [7:0] d);
        sfrAddr = a;
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b1;
        @(negedge clk);
        d = rdData;
    endtask
    task automatic wt(input int n);
        sfrWrEn = 1'b0;
        sfrRdEn = 1'b0;
        repeat (n) @(negedge clk);
    endtask
    task automatic pulses(input int n);
        wt(0);
        repeat (n)
        begin
            timer0Overflow = 1'b1;
            @(negedge clk);
            timer0Overflow = 1'b0;
            @(negedge clk);
        end
    endtask
    task automatic setTimer(input [15:0] t);
        wr(`CACC_ADDR_TIMER_LOW, t[7:0]);
        wr(`CACC_ADDR_TIMER_HIGH, t[15:8]);
    endtask
    task automatic chk(input string n, input [15:0] x, input [15:0] g);
        checks++;
        if (g !== x)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        wt(4);
        reset = 1'b0;
        rd(8'h80, v);
        chk("unmapped", 16'h0, v);
        rd(CTL, v);
        chk("control", `CACC_CTL_RESET, v);
        rd(MD, v);
        chk("mode", `CACC_MOD_RESET, v);
        chk("pins", 16'h1f, pinOut);
        for (i = 0; i < 4; i++)
        begin
            sixClockMode = i[0];
            wr(MD, i[1] ? 8'h02 : 8'h00);
            setTimer(16'h0);
            wr(CTL, 8'h40);
            wt(119);
            wr(CTL, 8'h00);
            rd(`CACC_ADDR_TIMER_LOW, v);
            e = 120 / (i[1] ? (i[0] ? `CACC_DIV_FAST_6CLK : `CACC_DIV_FAST_12CLK)
                : (i[0] ? `CACC_DIV_SLOW_6CLK : `CACC_DIV_SLOW_12CLK));
            checks++;
            if ($isunknown(v) || v + 1 < e || v > e + 1)
            begin
                mismatches++;
                $display("BAD rate expected %0d seen %0d", e, v);
            end
        end
        wr(MD, 8'h04);
        setTimer(16'h00fe);
        wr(CTL, 8'h40);
        pulses(3);
        rd(`CACC_ADDR_TIMER_LOW, v);
        rd(`CACC_ADDR_TIMER_HIGH, w);
        chk("carry", 16'h0101, {w, v});
        wr(MD, 8'h84);
        idleMode = 1'b1;
        pulses(2);
        idleMode = 1'b0;
        rd(`CACC_ADDR_TIMER_LOW, v);
        chk("idle", 16'h01, v);
        wr(MD, 8'h06);
        setTimer(16'h0);
        repeat (4)
        begin
            extCountDrive = 1'b1;
            wt(4);
            extCountDrive = 1'b0;
            wt(4);
        end
        rd(`CACC_ADDR_TIMER_LOW, v);
        chk("external", 16'h04, v);
        wr(MD, 8'h05);
        rd(MD, v);
        chk("mode rw", 16'h05, v);
        setTimer(16'hffff);
        pulses(1);
        rd(CTL, v);
        chk("overflow", 16'hc0, v);
        chk("irq", 16'h1, irq);
        pulses(1);
        rd(CTL, v);
        chk("held", 16'hc0, v);
        wr(CTL, 8'h00);
        rd(CTL, v);
        chk("cleared", 16'h0, v);
        wt(2);
        chk("irq off", 16'h0, irq);
        wr(8'hd1, 8'h4d);
        wr(8'he1, 8'h05);
        wr(8'hf1, 8'h00);
        wr(MD, 8'h04);
        setTimer(16'h0);
        wr(CTL, 8'h40);
        pulses(5);
        rd(CTL, v);
        chk("match", 16'h42, v);
        chk("toggle", 16'h1d, pinOut);
        chk("irq mod", 16'h1, irq);
        rd(8'hd1, v);
        chk("func", 16'h4d, v);
        wr(CTL, 8'h00);
        wr(8'hd1, 8'h00);
        setTimer(16'h1234);
        wr(8'hd2, 8'h20);
        pinDrive = 5'h1b;
        wt(4);
        rd(CTL, v);
        chk("no fall", 16'h0, v);
        pinDrive = 5'h1f;
        wt(4);
        rd(CTL, v);
        chk("rise", 16'h04, v);
        rd(8'he2, v);
        rd(8'hf2, w);
        chk("capture", 16'h1234, {w, v});
        wr(8'hd2, 8'h30);
        setTimer(16'h0abc);
        pinDrive = 5'h1b;
        wt(4);
        rd(8'he2, v);
        chk("both", 16'hbc, v);
        wr(8'hd2, 8'h10);
        setTimer(16'h0def);
        pinDrive = 5'h1f;
        wt(4);
        rd(8'he2, v);
        chk("fall only rise", 16'hbc, v);
        pinDrive = 5'h1b;
        wt(4);
        rd(8'he2, v);
        chk("fall only fall", 16'hef, v);
        wr(8'hd3, 8'h42);
        wr(8'he3, 8'h80);
        setTimer(16'h007f);
        wt(3);
        chk("pwm low", 16'h0, pinOut[3]);
        setTimer(16'h0080);
        wt(3);
        chk("pwm high", 16'h1, pinOut[3]);
        chk("pwm oe", 16'h08, pinOe);
        wr(8'hd3, 8'h00);
        wt(3);
        chk("oe off", 16'h0, pinOe);
        wr(8'hd4, 8'h48);
        wr(8'he4, 8'h02);
        wr(8'hf4, 8'h00);
        wr(MD, 8'h04);
        setTimer(16'h0);
        wr(CTL, 8'h40);
        pulses(2);
        wt(2);
        chk("no wdog", 16'h0, wdCount);
        wr(MD, 8'h44);
        setTimer(16'h0);
        pulses(2);
        wt(2);
        chk("wdog", 16'h1, wdCount);
        finish_test();
    end
endmodule
`default_nettype wire
